// file: src/pump_ctl_pkg.sv
// package: constants and types for the pump start/stop trigger block
package pump_ctl_pkg;
    // ========================================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    // cycles beyond the filter before the first edge may count
    localparam int SETTLE_PAD = 4;
    // ========================================================
    // control modes
    typedef enum logic [1:0] {
        MODE_KEYPAD = 2'b00,
        MODE_FOOTSWITCH = 2'b01,
        MODE_ANALOG = 2'b10,
        MODE_SERIAL = 2'b11
    } ctl_mode_t;
    // ========================================================
    // serial settings
    typedef enum logic [2:0] {
        BAUD_1200 = 3'b000,
        BAUD_2400 = 3'b001,
        BAUD_4800 = 3'b010,
        BAUD_9600 = 3'b011,
        BAUD_19200 = 3'b100,
        BAUD_38400 = 3'b101
    } baud_t;
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD = 2'b01,
        PAR_EVEN = 2'b10
    } parity_t;
    typedef enum logic [1:0] {
        PROTO_UNKNOWN = 2'b00,
        PROTO_MODBUS = 2'b01,
        PROTO_NATIVE = 2'b10
    } proto_t;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [5:0] ADDR_MAX_MODBUS = 6'h20;
    localparam logic [5:0] ADDR_MAX_NATIVE = 6'h1E;
    localparam logic [5:0] ADDR_RESET = 6'h01;
    localparam baud_t BAUD_RESET = BAUD_9600;
    localparam parity_t PAR_RESET = PAR_NONE;
    localparam logic STOP2_RESET = 1'b0;
    localparam logic PULSE_RESET = 1'b0;
    // first byte of a native-protocol frame; arbitrary value
    localparam logic [7:0] NATIVE_SOF = 8'hE9;
    // pump run state machine
    typedef enum logic [1:0] {
        ST_ARM = 2'b00,
        ST_STOP = 2'b01,
        ST_RUN = 2'b10
    } run_st_t;
endpackage : pump_ctl_pkg

// file: src/input_conditioner.sv
// module: two-stage synchroniser and debounce filter for the start input
`timescale 1ns/1ps
module input_conditioner
    import pump_ctl_pkg::*;
#(
    parameter int FILT_CYC = DEBOUNCE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic raw_in,
    output logic clean_r
);
    localparam int CW = $clog2(FILT_CYC + 1);
    initial begin
        if (FILT_CYC < 1) $error("filter length must be at least one");
    end
    logic s1_r, s2_r, clean_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    // ========================================================
    // bounce filter: level must hold FILT_CYC cycles to be taken
    always_comb begin
        clean_nxt = clean_r;
        cnt_nxt = '0;
        if (s2_r != clean_r) begin
            if (cnt_r == CW'(FILT_CYC - 1)) begin
                clean_nxt = s2_r;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end
    // first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            clean_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            clean_r <= clean_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    a_filter_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        $changed(clean_r) |-> $past(s2_r) == clean_r)
        else $error("filtered level changed without matching input");
endmodule : input_conditioner

// file: src/pump_start_stop_trigger.sv
// module: pump start/stop trigger logic with serial link settings
// ============================================================
`timescale 1ns/1ps
module pump_start_stop_trigger
    import pump_ctl_pkg::*;
#(
    parameter int FILT_CYC = DEBOUNCE_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start_in,
    input wire logic switch_type,
    input wire ctl_mode_t ctl_mode,
    input wire logic edit_active,
    input wire logic edit_pulse_mode,
    input wire logic [5:0] edit_addr,
    input wire baud_t edit_baud,
    input wire parity_t edit_parity,
    input wire logic edit_stop2,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_first_byte,
    output logic pump_run_r,
    output logic pulse_mode_r,
    output logic [5:0] node_addr_r,
    output baud_t baud_r,
    output parity_t parity_r,
    output logic stop2_r,
    output proto_t proto_r,
    output logic addr_match_r,
    output logic footswitch_control_mode_r
);
    initial begin
        if (FILT_CYC < 1) $error("filter length must be at least one");
    end
    // ========================================================
    // reset release
    logic rs1_r, rst_n;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end
    // ========================================================
    // input conditioning
    logic clean;
    input_conditioner #(.FILT_CYC(FILT_CYC)) input_conditioner_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw_in(start_in),
        .clean_r(clean)
    );
    // active = high for level signal, open contact for switch
    logic active, clean_d_r, seen_r;
    logic rise, change;
    logic fs_mode;
    assign active = switch_type ? ~clean : clean;
    // edges come from the pin itself, so a change of switch_type is no edge;
    // nothing counts until the filter has settled on the real pin level,
    // else the filter's reset value would fake an edge after power-up
    assign change = seen_r & (clean != clean_d_r);
    assign rise = change & active;
    assign fs_mode = (ctl_mode == MODE_FOOTSWITCH) || (ctl_mode == MODE_ANALOG);
    // ========================================================
    // applied settings, loaded on leaving the edit screen
    logic edit_d_r, commit;
    logic pulse_nxt, stop2_nxt;
    logic [5:0] addr_nxt;
    baud_t baud_nxt;
    parity_t parity_nxt;
    assign commit = edit_d_r & ~edit_active;
    function automatic logic baud_ok(input baud_t b);
        baud_ok = (b <= BAUD_38400);
    endfunction : baud_ok
    function automatic logic addr_ok(input logic [5:0] a, input proto_t p);
        addr_ok = (a >= ADDR_MIN) &&
            (a <= ((p == PROTO_NATIVE) ? ADDR_MAX_NATIVE : ADDR_MAX_MODBUS));
    endfunction : addr_ok
    always_comb begin
        pulse_nxt = pulse_mode_r;
        addr_nxt = node_addr_r;
        baud_nxt = baud_r;
        parity_nxt = parity_r;
        stop2_nxt = stop2_r;
        if (commit) begin
            // mode only changes while stopped in footswitch mode
            if (ctl_mode == MODE_FOOTSWITCH && !pump_run_r) begin
                pulse_nxt = edit_pulse_mode;
            end
            if (addr_ok(edit_addr, PROTO_MODBUS)) begin
                addr_nxt = edit_addr;
            end
            if (baud_ok(edit_baud)) begin
                baud_nxt = edit_baud;
            end
            if (edit_parity != 2'b11) begin
                parity_nxt = edit_parity;
            end
            stop2_nxt = edit_stop2;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            edit_d_r <= 1'b0;
            pulse_mode_r <= PULSE_RESET;
            node_addr_r <= ADDR_RESET;
            baud_r <= BAUD_RESET;
            parity_r <= PAR_RESET;
            stop2_r <= STOP2_RESET;
        end else begin
            edit_d_r <= edit_active;
            pulse_mode_r <= pulse_nxt;
            node_addr_r <= addr_nxt;
            baud_r <= baud_nxt;
            parity_r <= parity_nxt;
            stop2_r <= stop2_nxt;
        end
    end
    // ========================================================
    // run state: ST_ARM waits for the first proper edge after power-up
    run_st_t st_r, st_nxt;
    logic half_r, half_nxt, seen_nxt;
    // settle time: two sync stages, the filter and a small margin
    localparam int SETTLE_CYC = FILT_CYC + SETTLE_PAD;
    localparam int SW = $clog2(SETTLE_CYC + 1);
    logic [SW-1:0] settle_r, settle_nxt;
    always_comb begin
        st_nxt = st_r;
        half_nxt = half_r;
        settle_nxt = settle_r;
        if (settle_r != SW'(SETTLE_CYC)) begin
            settle_nxt = settle_r + 1'b1;
        end
        seen_nxt = (settle_nxt == SW'(SETTLE_CYC));
        if (!fs_mode) begin
            // keypad or serial owns the pump; input ignored
            st_nxt = ST_ARM;
            half_nxt = 1'b0;
        end else if (!pulse_mode_r) begin
            case (st_r)
                ST_ARM: begin
                    if (rise) st_nxt = ST_RUN;
                end
                ST_STOP: begin
                    if (active) st_nxt = ST_RUN;
                end
                ST_RUN: begin
                    if (!active) st_nxt = ST_STOP;
                end
                default: st_nxt = ST_ARM;
            endcase
        end else if (change) begin
            // second change completes the pulse and toggles
            half_nxt = ~half_r;
            if (half_r) begin
                st_nxt = ST_RUN;
                if (st_r == ST_RUN) st_nxt = ST_STOP;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_ARM;
            half_r <= 1'b0;
            clean_d_r <= 1'b0;
            seen_r <= 1'b0;
            settle_r <= '0;
            pump_run_r <= 1'b0;
            footswitch_control_mode_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            half_r <= half_nxt;
            clean_d_r <= clean;
            seen_r <= seen_nxt;
            settle_r <= settle_nxt;
            pump_run_r <= (st_nxt == ST_RUN);
            footswitch_control_mode_r <= (ctl_mode == MODE_FOOTSWITCH);
        end
    end
    // ========================================================
    // protocol identification from the first byte of each frame
    proto_t proto_nxt;
    logic match_nxt;
    always_comb begin
        proto_nxt = proto_r;
        match_nxt = addr_match_r;
        if (rx_byte_valid && rx_first_byte) begin
            proto_nxt = PROTO_MODBUS;
            if (rx_byte == NATIVE_SOF) proto_nxt = PROTO_NATIVE;
            match_nxt = 1'b0;
        end else if (rx_byte_valid && proto_r == PROTO_NATIVE) begin
            // native frames carry the address in the second byte
            match_nxt = (rx_byte[5:0] == node_addr_r) && (rx_byte[7:6] == 2'b00)
                && addr_ok(node_addr_r, PROTO_NATIVE);
        end
        if (rx_byte_valid && rx_first_byte && rx_byte != NATIVE_SOF) begin
            match_nxt = (rx_byte == {2'b00, node_addr_r});
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            proto_r <= PROTO_UNKNOWN;
            addr_match_r <= 1'b0;
        end else begin
            proto_r <= proto_nxt;
            addr_match_r <= match_nxt;
        end
    end
    // ========================================================
    // checks
    a_arm_no_run: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !pulse_mode_r && st_r == ST_ARM && !rise |=> !pump_run_r)
        else $error("pump ran without first edge");
    // the filter's reset level must never look like a first edge
    a_settle_quiet: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !seen_r |=> !pump_run_r)
        else $error("pump ran before input settled");
    a_level_follow: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        fs_mode && !pulse_mode_r && st_r != ST_ARM && !active
        |=> !pump_run_r)
        else $error("pump running with inactive level");
    a_switch_open: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        switch_type && fs_mode && !pulse_mode_r && st_r == ST_STOP && !clean
        |=> pump_run_r)
        else $error("open switch did not start pump");
    a_arm_edge: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        fs_mode && !pulse_mode_r && st_r == ST_ARM && rise |=> pump_run_r)
        else $error("first edge did not start pump");
    a_pulse_toggle: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        fs_mode && pulse_mode_r && change && half_r
        |=> pump_run_r != $past(pump_run_r))
        else $error("pulse did not toggle");
    a_half_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        fs_mode && pulse_mode_r && change && !half_r
        |=> pump_run_r == $past(pump_run_r))
        else $error("toggled on first change");
    a_switch_pulse: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        switch_type && fs_mode && pulse_mode_r && change && half_r
        |=> half_r == 1'b0)
        else $error("switch pulse pairing lost");
    a_serial_ign: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !fs_mode |=> !pump_run_r)
        else $error("input drove pump outside footswitch mode");
    a_mode_lock: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        $changed(pulse_mode_r)
        |-> $past(commit) && !$past(pump_run_r)
        && $past(ctl_mode) == MODE_FOOTSWITCH)
        else $error("mode changed while running");
    a_commit_only: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !commit |=> $stable(baud_r) && $stable(parity_r) && $stable(stop2_r)
        && $stable(node_addr_r))
        else $error("setting changed before run screen");
    a_baud_range: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        baud_r <= BAUD_38400 && parity_r != 2'b11)
        else $error("illegal baud or parity");
    a_addr_range: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        node_addr_r >= ADDR_MIN && node_addr_r <= ADDR_MAX_MODBUS)
        else $error("address out of range");
    a_proto_id: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        rx_byte_valid && rx_first_byte && rx_byte == NATIVE_SOF
        |=> proto_r == PROTO_NATIVE)
        else $error("native frame not identified");
    a_stop_bits: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        commit |=> stop2_r == $past(edit_stop2))
        else $error("stop bit setting not applied");
    a_parity_apply: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        commit && edit_parity != 2'b11 |=> parity_r == $past(edit_parity))
        else $error("parity setting not applied");
    c_level_run: cover property (@(posedge core_clk) disable iff (!rst_n)
        !pulse_mode_r && $rose(pump_run_r));
    c_pulse_toggle: cover property (@(posedge core_clk) disable iff (!rst_n)
        pulse_mode_r && $fell(pump_run_r));
    c_commit: cover property (@(posedge core_clk) disable iff (!rst_n) commit);
    c_native: cover property (@(posedge core_clk) disable iff (!rst_n)
        proto_r == PROTO_NATIVE && addr_match_r);
endmodule : pump_start_stop_trigger

// file: verif/start_source.sv
// partner model: footswitch or plc driving the start/stop input
`timescale 1ns/1ps
module start_source #(
    parameter int HOLD_CYC = 12
) (
    input wire logic core_clk,
    output logic start_in
);
    // ========================================================
    // level source
    // starts high so power-up sees a static active level
    initial start_in = 1'b1;

    // one change, optionally with a chatter burst first; the level then
    // holds long enough for the device filter to accept it
    task automatic change_to(input logic lvl, input logic chatter);
        @(negedge core_clk);
        if (chatter) begin
            start_in = lvl;
            @(negedge core_clk);
            start_in = ~lvl;
            @(negedge core_clk);
        end
        start_in = lvl;
        repeat (HOLD_CYC) @(negedge core_clk);
    endtask : change_to

    // both level changes of a pulse come from this side
    task automatic pulse();
        change_to(~start_in, 1'b0);
        change_to(~start_in, 1'b0);
    endtask : pulse
endmodule : start_source

// file: verif/tb_pump_start_stop_trigger.sv
// testbench: pump start/stop trigger against an external source model
`timescale 1ns/1ps
module tb_pump_start_stop_trigger;
    import pump_ctl_pkg::*;
    localparam int FILT = 3;
    logic core_clk, nrst, start_in, switch_type, edit_active;
    logic edit_pulse_mode, edit_stop2, rx_byte_valid, rx_first_byte;
    logic [5:0] edit_addr;
    logic [7:0] rx_byte;
    ctl_mode_t ctl_mode;
    baud_t edit_baud;
    parity_t edit_parity;
    logic pump_run_r, pulse_mode_r, stop2_r, addr_match_r;
    logic footswitch_control_mode_r;
    logic [5:0] node_addr_r;
    baud_t baud_r;
    parity_t parity_r;
    proto_t proto_r;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    pump_start_stop_trigger #(.FILT_CYC(FILT)) pump_start_stop_trigger_i (
        .core_clk(core_clk), .nrst(nrst), .start_in(start_in),
        .switch_type(switch_type), .ctl_mode(ctl_mode),
        .edit_active(edit_active), .edit_pulse_mode(edit_pulse_mode),
        .edit_addr(edit_addr), .edit_baud(edit_baud),
        .edit_parity(edit_parity), .edit_stop2(edit_stop2),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_first_byte(rx_first_byte), .pump_run_r(pump_run_r),
        .pulse_mode_r(pulse_mode_r), .node_addr_r(node_addr_r),
        .baud_r(baud_r), .parity_r(parity_r), .stop2_r(stop2_r),
        .proto_r(proto_r), .addr_match_r(addr_match_r),
        .footswitch_control_mode_r(footswitch_control_mode_r)
    );
    start_source start_source_i (.core_clk(core_clk), .start_in(start_in));

    // ========================================================
    // clock and hang guard; the run needs well under 3000 cycles
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            summarize();
        end
    end

    // ========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // reset held four cycles; switch type chosen while in reset
    task automatic reset_dut(input logic sw);
        @(negedge core_clk);
        nrst = 1'b0;
        switch_type = sw;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask : reset_dut

    // edit screen shown, then left; settings apply on the first rising clock edge after the fall
    task automatic commit(input logic pm, input logic [5:0] a,
                          input baud_t b, input parity_t p, input logic s2);
        @(negedge core_clk);
        edit_active = 1'b1;
        edit_pulse_mode = pm;
        edit_addr = a;
        edit_baud = b;
        edit_parity = p;
        edit_stop2 = s2;
        repeat (3) @(negedge core_clk);
        edit_active = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : commit

    task automatic send(input logic [7:0] b, input logic first);
        @(negedge core_clk);
        rx_byte_valid = 1'b1;
        rx_byte = b;
        rx_first_byte = first;
        @(negedge core_clk);
        rx_byte_valid = 1'b0;
        rx_first_byte = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : send

    // ========================================================
    // scenarios
    task automatic test_level();
        check(node_addr_r, ADDR_RESET, "reset address");
        check(baud_r, BAUD_RESET, "reset baud");
        check(proto_r, PROTO_UNKNOWN, "reset proto");
        repeat (20) @(negedge core_clk);
        check(pump_run_r, 1'b0, "static high ran");
        check(footswitch_control_mode_r, 1'b1, "mode flag");
        start_source_i.change_to(1'b0, 1'b1);
        check(pump_run_r, 1'b0, "low ran");
        start_source_i.change_to(1'b1, 1'b1);
        check(pump_run_r, 1'b1, "high stopped");
        start_source_i.change_to(1'b0, 1'b0);
        check(pump_run_r, 1'b0, "low ran");
    endtask : test_level

    // second reset mid-run with contacts open and static
    task automatic test_switch();
        reset_dut(1'b1);
        repeat (20) @(negedge core_clk);
        check(pump_run_r, 1'b0, "static open ran");
        start_source_i.change_to(1'b1, 1'b1);
        check(pump_run_r, 1'b0, "closed ran");
        start_source_i.change_to(1'b0, 1'b1);
        check(pump_run_r, 1'b1, "open stopped");
        start_source_i.change_to(1'b1, 1'b0);
        check(pump_run_r, 1'b0, "closed ran");
    endtask : test_switch

    task automatic test_pulse();
        commit(1'b1, 6'h01, BAUD_9600, PAR_NONE, 1'b0);
        check(pulse_mode_r, 1'b1, "pulse commit");
        start_source_i.change_to(1'b0, 1'b1);
        check(pump_run_r, 1'b0, "one change acted");
        start_source_i.change_to(1'b1, 1'b1);
        check(pump_run_r, 1'b1, "switch pulse");
        commit(1'b0, 6'h01, BAUD_9600, PAR_NONE, 1'b0);
        check(pulse_mode_r, 1'b1, "edit while running");
        switch_type = 1'b0;
        start_source_i.change_to(1'b0, 1'b0);
        check(pump_run_r, 1'b1, "one change acted");
        start_source_i.change_to(1'b1, 1'b0);
        check(pump_run_r, 1'b0, "level pulse");
        start_source_i.pulse();
        check(pump_run_r, 1'b1, "second pulse");
    endtask : test_pulse

    task automatic test_mode();
        ctl_mode = MODE_KEYPAD;
        repeat (4) @(negedge core_clk);
        check(pump_run_r, 1'b0, "keypad run");
        check(footswitch_control_mode_r, 1'b0, "mode flag");
        ctl_mode = MODE_FOOTSWITCH;
        commit(1'b0, 6'h01, BAUD_9600, PAR_NONE, 1'b0);
        check(pulse_mode_r, 1'b0, "level commit");
        ctl_mode = MODE_ANALOG;
        commit(1'b1, 6'h01, BAUD_9600, PAR_NONE, 1'b0);
        check(pulse_mode_r, 1'b0, "edit outside footswitch");
        check(footswitch_control_mode_r, 1'b0, "analog flag");
        start_source_i.change_to(1'b0, 1'b0);
        start_source_i.change_to(1'b1, 1'b0);
        check(pump_run_r, 1'b1, "analog start");
        start_source_i.change_to(1'b0, 1'b0);
        check(pump_run_r, 1'b0, "analog stop");
        ctl_mode = MODE_SERIAL;
        start_source_i.change_to(1'b1, 1'b0);
        check(pump_run_r, 1'b0, "serial run");
        ctl_mode = MODE_FOOTSWITCH;
    endtask : test_mode

    task automatic test_serial();
        @(negedge core_clk);
        edit_active = 1'b1;
        edit_baud = BAUD_38400;
        repeat (3) @(negedge core_clk);
        check(baud_r, BAUD_9600, "applied early");
        for (int i = 0; i < 6; i++) begin
            commit(1'b0, 6'h20, baud_t'(i), parity_t'(i % 3), i[0]);
            check(baud_r, baud_t'(i), "baud");
            check(parity_r, parity_t'(i % 3), "parity");
            check(stop2_r, i[0], "stop bits");
            check(node_addr_r, 6'h20, "address");
        end
        commit(1'b0, 6'h00, baud_t'(3'h6), parity_t'(2'h3), 1'b1);
        check(node_addr_r, 6'h20, "address 0 kept");
        check(baud_r, BAUD_38400, "bad baud kept");
        check(parity_r, PAR_EVEN, "bad parity kept");
        commit(1'b0, 6'h21, BAUD_38400, PAR_EVEN, 1'b1);
        check(node_addr_r, 6'h20, "address 33 kept");
        commit(1'b0, 6'h01, BAUD_9600, PAR_NONE, 1'b0);
    endtask : test_serial

    task automatic test_proto();
        send(8'h05, 1'b1);
        check(proto_r, PROTO_MODBUS, "modbus frame");
        check(addr_match_r, 1'b0, "other address");
        send(8'h01, 1'b1);
        check(addr_match_r, 1'b1, "own address");
        send(NATIVE_SOF, 1'b1);
        send(8'h01, 1'b0);
        check(proto_r, PROTO_NATIVE, "native frame");
        check(addr_match_r, 1'b1, "native own address");
        // 31 is legal for modbus but beyond the native range
        commit(1'b0, 6'h1F, BAUD_9600, PAR_NONE, 1'b0);
        send(NATIVE_SOF, 1'b1);
        send(8'h1F, 1'b0);
        check(addr_match_r, 1'b0, "native address 31");
        send(8'h1F, 1'b1);
        check(addr_match_r, 1'b1, "modbus address 31");
    endtask : test_proto

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // ========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        switch_type = 1'b0;
        ctl_mode = MODE_FOOTSWITCH;
        edit_active = 1'b0;
        edit_pulse_mode = 1'b0;
        edit_addr = 6'h01;
        edit_baud = BAUD_9600;
        edit_parity = PAR_NONE;
        edit_stop2 = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_first_byte = 1'b0;
        reset_dut(1'b0);
        test_level();
        test_switch();
        test_pulse();
        test_mode();
        test_serial();
        test_proto();
        summarize();
    end
endmodule : tb_pump_start_stop_trigger
